// File: design/nv_ctrl_pkg.sv
`default_nettype none
package nv_ctrl_pkg;

  // Register offsets on the plain register port
  localparam logic [3:0] REG_CONTROL     = 4'h0; // nv_control
  localparam logic [3:0] REG_UNLOCK      = 4'h1; // nv_unlock_port
  localparam logic [3:0] REG_ADDR_LOW    = 4'h2; // nv_address_low
  localparam logic [3:0] REG_ADDR_HIGH   = 4'h3; // nv_address_high
  localparam logic [3:0] REG_DATA        = 4'h4; // EEPROM data byte
  localparam logic [3:0] REG_TABLE_LATCH = 4'h5; // table_byte_latch
  localparam logic [3:0] REG_TPTR_LOW    = 4'h6; // Table pointer low
  localparam logic [3:0] REG_TPTR_HIGH   = 4'h7; // Table pointer high
  localparam logic [3:0] REG_TABLE_CMD   = 4'h8; // Table read/write command
  localparam logic [3:0] REG_STATUS      = 4'h9; // Read-only status

  // nv_control bit positions
  localparam int CTL_FLASH_SEL  = 7; // flash_or_data_select
  localparam int CTL_CFG_SEL    = 6; // config_space_select
  localparam int CTL_BULK_ERASE = 5; // Bulk erase request, always refused
  localparam int CTL_ERASE_SEL  = 4; // Flash start means erase, not write
  localparam int CTL_WR_ERROR   = 3; // Sticky refused-request flag
  localparam int CTL_WR_ENABLE  = 2; // nv_write_enable
  localparam int CTL_WR_START   = 1; // Write start, self-clearing
  localparam int CTL_RD_STROBE  = 0; // Read strobe, self-clearing

  // Table command bit positions
  localparam int TCMD_READ    = 0; // Flash byte into table latch
  localparam int TCMD_WRITE   = 1; // Table latch into holding register
  localparam int TCMD_POSTINC = 2; // Advance pointer after the access

  // Status bit positions
  localparam int STAT_POWERUP = 0; // Power-up timer still running
  localparam int STAT_BUSY    = 1; // Write or erase in progress
  localparam int STAT_ARMED   = 2; // Unlock sequence complete

  // Unlock key values
  localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2 = 8'haa;

  // Values after reset and for erased bytes
  localparam logic [7:0]  BYTE_RESET  = 8'h00;
  localparam logic [7:0]  ERASED_BYTE = 8'hff;
  localparam logic [15:0] WORD_RESET  = 16'h0000;

  // Array geometry
  localparam int EE_BYTES    = 1024;
  localparam int FLASH_BYTES = 65536;
  localparam int BLOCK_BYTES = 64;

  // Timing, in microseconds, and the clock rate
  localparam int CLK_MHZ           = 125;
  localparam int POWERUP_TIME_US   = 1000;
  localparam int EE_WRITE_TIME_US  = 4000;
  localparam int FLASH_PROG_TIME_US = 2000;

  // Cycle counter and operation states
  typedef logic [23:0] cnt_type;
  typedef enum logic [1:0] {
    ST_IDLE, ST_EE_WRITE, ST_FL_WRITE, ST_FL_ERASE
  } op_state_type;

endpackage

`default_nettype wire

// File: design/nonvolatile_write_protect_ctrl.sv
// Operation
// - Code protect refuses external programming accesses
// - Processor reads and writes data EEPROM whatever the code protect
// - Power-up clears the write enable bit
// - No EEPROM write during power-up timer
// - Start needs write enable and unlock
// - Write-start bit stays set until done
// - EEPROM accessed one byte per address
// - Flash reads return one byte each
// - Flash writes commit whole 64-byte blocks
// - Flash erase by 64-byte blocks, no bulk
// - Bulk erase from user code is rejected
// - Fetches stall during flash write/erase
// - Internal timer ends flash write/erase
// - Any pattern accepted; invalid opcode is NOP
// - Flash bytes pass through table latch
// - Table writes fill holding registers first
//
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module nonvolatile_write_protect_ctrl #(
  parameter int POWERUP_CYCLES =
    nv_ctrl_pkg::POWERUP_TIME_US * nv_ctrl_pkg::CLK_MHZ,
  parameter int EE_WRITE_CYCLES =
    nv_ctrl_pkg::EE_WRITE_TIME_US * nv_ctrl_pkg::CLK_MHZ,
  parameter int FLASH_PROG_CYCLES =
    nv_ctrl_pkg::FLASH_PROG_TIME_US * nv_ctrl_pkg::CLK_MHZ
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  // Register port from the processor
  input  wire logic [3:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [7:0]  reg_rdata_out,
  // Instruction fetch port
  input  wire logic [14:0] fetch_addr_in,
  output logic      [15:0] fetch_data_out,
  output logic             fetch_stall_out,
  // External programming port to the data EEPROM
  input  wire logic        code_protect_in,
  input  wire logic        ext_rd_in,
  input  wire logic        ext_wr_in,
  input  wire logic [9:0]  ext_addr_in,
  input  wire logic [7:0]  ext_wdata_in,
  output logic      [7:0]  ext_rdata_out,
  output logic             ext_refused_out
);
  import nv_ctrl_pkg::*;

  // Storage arrays; contents are not reset, as in a real array
  logic [7:0] ee_mem    [0:EE_BYTES-1];    // Data EEPROM bytes
  logic [7:0] flash_mem [0:FLASH_BYTES-1]; // Program flash bytes
  logic [7:0] hold_mem  [0:BLOCK_BYTES-1]; // Flash holding registers

  // Control register fields
  logic         sel_flash_q, sel_flash_d;   // flash_or_data_select
  logic         sel_cfg_q, sel_cfg_d;       // config_space_select
  logic         erase_sel_q, erase_sel_d;   // Erase instead of write
  logic         err_q, err_d;               // Sticky refused flag
  logic         wr_en_q, wr_en_d;           // nv_write_enable
  logic         wr_q, wr_d;                 // Write start / busy
  logic         rd_q, rd_d;                 // Read strobe
  logic [1:0]   unlock_q, unlock_d;         // Unlock sequence stage
  // Address, data and table registers
  logic [7:0]   addr_lo_q, addr_lo_d;       // nv_address_low
  logic [7:0]   addr_hi_q, addr_hi_d;       // nv_address_high
  logic [7:0]   data_q, data_d;             // EEPROM data byte
  logic [7:0]   latch_q, latch_d;           // table_byte_latch
  logic [15:0]  tptr_q, tptr_d;             // Table pointer
  // Sequencing state
  op_state_type state_q, state_d;           // Current operation
  cnt_type      cnt_q, cnt_d;               // Programming timer
  cnt_type      pwr_cnt_q, pwr_cnt_d;       // Power-up timer
  logic         pwr_busy_q, pwr_busy_d;     // Power-up window open
  // Output registers
  logic [7:0]   rdata_q, rdata_d;
  logic [15:0]  fdata_q, fdata_d;
  logic         stall_q, stall_d;
  logic [7:0]   ext_rdata_q, ext_rdata_d;
  logic         ext_ref_q, ext_ref_d;
  // Memory write commands, decoded combinationally
  logic         ee_commit;                  // EEPROM write from core
  logic         ext_commit;                 // EEPROM write from outside
  logic         hold_wr;                    // Holding register load
  logic         fl_commit;                  // Block program
  logic         fl_erase;                   // Block erase
  logic         start_req, start_ok;
  logic         ext_ok;
  logic [9:0]   ee_addr;
  logic [9:0]   blk;                        // 64-byte block index

  // Register write hit on one offset
  function automatic logic wr_hit(input logic [3:0] off);
    return reg_wr_in && (reg_addr_in == off);
  endfunction

  // Byte address inside the EEPROM
  assign ee_addr = {addr_hi_q[1:0], addr_lo_q};
  assign blk     = tptr_q[15:6];

  // Next state of all control, sequencing and output registers
  always_comb begin
    sel_flash_d = sel_flash_q;
    sel_cfg_d   = sel_cfg_q;
    erase_sel_d = erase_sel_q;
    err_d       = err_q;
    wr_en_d     = wr_en_q;
    wr_d        = wr_q;
    rd_d        = 1'b0;
    unlock_d    = unlock_q;
    addr_lo_d   = addr_lo_q;
    addr_hi_d   = addr_hi_q;
    data_d      = data_q;
    latch_d     = latch_q;
    tptr_d      = tptr_q;
    state_d     = state_q;
    cnt_d       = cnt_q;
    pwr_cnt_d   = pwr_cnt_q;
    pwr_busy_d  = pwr_busy_q;
    rdata_d     = BYTE_RESET;
    ext_rdata_d = BYTE_RESET;
    ext_ref_d   = 1'b0;
    ee_commit   = 1'b0;
    ext_commit  = 1'b0;
    hold_wr     = 1'b0;
    fl_commit   = 1'b0;
    fl_erase    = 1'b0;

    // Power-up timer; only EEPROM writes are held off by it
    if (pwr_busy_q) begin
      if (pwr_cnt_q == cnt_type'(POWERUP_CYCLES - 1)) begin
        pwr_busy_d = 1'b0;
      end else begin
        pwr_cnt_d = pwr_cnt_q + cnt_type'(1);
      end
    end

    // Start honoured only once write enable and unlock came earlier
    start_req = wr_hit(REG_CONTROL) && reg_wdata_in[CTL_WR_START];
    start_ok  = start_req && wr_en_q && (unlock_q == 2'd2) &&
                (state_q == ST_IDLE) && !sel_cfg_q &&
                (sel_flash_q || !pwr_busy_q);

    // Simple register writes
    if (wr_hit(REG_ADDR_LOW)) begin
      addr_lo_d = reg_wdata_in;
    end
    if (wr_hit(REG_ADDR_HIGH)) begin
      addr_hi_d = reg_wdata_in;
    end
    if (wr_hit(REG_DATA)) begin
      data_d = reg_wdata_in;
    end
    if (wr_hit(REG_TABLE_LATCH)) begin
      latch_d = reg_wdata_in;
    end
    if (wr_hit(REG_TPTR_LOW)) begin
      tptr_d[7:0] = reg_wdata_in;
    end
    if (wr_hit(REG_TPTR_HIGH)) begin
      tptr_d[15:8] = reg_wdata_in;
    end

    // Unlock port: 55h arms stage one, AAh right after it completes
    if (wr_hit(REG_UNLOCK)) begin
      if (reg_wdata_in == UNLOCK_KEY1) begin
        unlock_d = 2'd1;
      end else if (reg_wdata_in == UNLOCK_KEY2 && unlock_q == 2'd1) begin
        unlock_d = 2'd2;
      end else begin
        unlock_d = 2'd0;
      end
    end

    // Control register: start and read bits can only be set by software
    if (wr_hit(REG_CONTROL)) begin
      sel_flash_d = reg_wdata_in[CTL_FLASH_SEL];
      sel_cfg_d   = reg_wdata_in[CTL_CFG_SEL];
      erase_sel_d = reg_wdata_in[CTL_ERASE_SEL];
      wr_en_d     = reg_wdata_in[CTL_WR_ENABLE];
      // Software clears the error flag by writing zero
      if (!reg_wdata_in[CTL_WR_ERROR]) begin
        err_d = 1'b0;
      end
      // Any control write uses up the unlock, spent or not
      unlock_d = 2'd0;
      // Read strobe toward the EEPROM only with both selects clear
      if (reg_wdata_in[CTL_RD_STROBE] && !reg_wdata_in[CTL_FLASH_SEL] &&
          !reg_wdata_in[CTL_CFG_SEL] && state_q != ST_EE_WRITE) begin
        rd_d = 1'b1;
      end
    end

    // Read strobe fetches the byte for the next instruction
    if (rd_q) begin
      data_d = ee_mem[ee_addr];
    end

    // Table operations move flash bytes through the latch
    if (wr_hit(REG_TABLE_CMD) && state_q == ST_IDLE) begin
      if (reg_wdata_in[TCMD_READ]) begin
        latch_d = flash_mem[tptr_q];
      end
      if (reg_wdata_in[TCMD_WRITE]) begin
        hold_wr = 1'b1;
      end
      if (reg_wdata_in[TCMD_POSTINC]) begin
        tptr_d = tptr_q + 16'h0001;
      end
    end

    // Operation sequencer
    unique case (state_q)
      ST_IDLE: begin
        if (start_ok) begin
          wr_d  = 1'b1;
          cnt_d = '0;
          if (!sel_flash_q) begin
            state_d = ST_EE_WRITE;
          end else if (erase_sel_q) begin
            state_d = ST_FL_ERASE;
          end else begin
            state_d = ST_FL_WRITE;
          end
        end
      end
      ST_EE_WRITE: begin
        if (cnt_q == cnt_type'(EE_WRITE_CYCLES - 1)) begin
          ee_commit = 1'b1;
          wr_d      = 1'b0;
          state_d   = ST_IDLE;
        end else begin
          cnt_d = cnt_q + cnt_type'(1);
        end
      end
      ST_FL_WRITE, ST_FL_ERASE: begin
        // The timer alone ends the operation; software cannot
        if (cnt_q == cnt_type'(FLASH_PROG_CYCLES - 1)) begin
          fl_commit = (state_q == ST_FL_WRITE);
          fl_erase  = (state_q == ST_FL_ERASE);
          wr_d      = 1'b0;
          state_d   = ST_IDLE;
        end else begin
          cnt_d = cnt_q + cnt_type'(1);
        end
      end
    endcase

    // Starts refused while idle and bulk erase raise the flag; a new refusal beats the clear
    if ((start_req && !start_ok && !wr_q) ||
        (wr_hit(REG_CONTROL) && reg_wdata_in[CTL_BULK_ERASE])) begin
      err_d = 1'b1;
    end

    // Fetches halt for the whole of a flash write or erase
    stall_d = (state_d == ST_FL_WRITE) || (state_d == ST_FL_ERASE);
    if (stall_d) begin
      fdata_d = fdata_q;
    end else begin
      // Raw word; invalid opcodes are left for the core to run as NOP
      fdata_d = {flash_mem[{fetch_addr_in, 1'b1}],
                 flash_mem[{fetch_addr_in, 1'b0}]};
    end

    // External port: shut out by code protect or a busy array
    // Writes from outside also wait out the power-up timer
    ext_ok    = !code_protect_in && (state_q == ST_IDLE);
    ext_ref_d = ((ext_rd_in || ext_wr_in) && !ext_ok) ||
                (ext_wr_in && pwr_busy_q);
    if (ext_rd_in && ext_ok) begin
      ext_rdata_d = ee_mem[ext_addr_in];
    end
    ext_commit = ext_wr_in && ext_ok && !pwr_busy_q;

    // Register read data, presented for one cycle only
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        REG_CONTROL: begin
          rdata_d = BYTE_RESET;
          rdata_d[CTL_FLASH_SEL] = sel_flash_q;
          rdata_d[CTL_CFG_SEL]   = sel_cfg_q;
          rdata_d[CTL_ERASE_SEL] = erase_sel_q;
          rdata_d[CTL_WR_ERROR]  = err_q;
          rdata_d[CTL_WR_ENABLE] = wr_en_q;
          rdata_d[CTL_WR_START]  = wr_q;
          rdata_d[CTL_RD_STROBE] = rd_q;
        end
        REG_ADDR_LOW:    rdata_d = addr_lo_q;
        REG_ADDR_HIGH:   rdata_d = addr_hi_q;
        REG_DATA:        rdata_d = data_q;
        REG_TABLE_LATCH: rdata_d = latch_q;
        REG_TPTR_LOW:    rdata_d = tptr_q[7:0];
        REG_TPTR_HIGH:   rdata_d = tptr_q[15:8];
        REG_STATUS: begin
          rdata_d = BYTE_RESET;
          rdata_d[STAT_POWERUP] = pwr_busy_q;
          rdata_d[STAT_BUSY]    = (state_q != ST_IDLE);
          rdata_d[STAT_ARMED]   = (unlock_q == 2'd2);
        end
        // Unlock port, command port and holes read as zero
        default:         rdata_d = BYTE_RESET;
      endcase
    end
  end

  // Control and output registers
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      sel_flash_q <= 1'b0;
      sel_cfg_q   <= 1'b0;
      erase_sel_q <= 1'b0;
      err_q       <= 1'b0;
      wr_en_q     <= 1'b0;
      wr_q        <= 1'b0;
      rd_q        <= 1'b0;
      unlock_q    <= 2'd0;
      addr_lo_q   <= BYTE_RESET;
      addr_hi_q   <= BYTE_RESET;
      data_q      <= BYTE_RESET;
      latch_q     <= BYTE_RESET;
      tptr_q      <= WORD_RESET;
      state_q     <= ST_IDLE;
      cnt_q       <= '0;
      pwr_cnt_q   <= '0;
      pwr_busy_q  <= 1'b1;
      rdata_q     <= BYTE_RESET;
      fdata_q     <= WORD_RESET;
      stall_q     <= 1'b0;
      ext_rdata_q <= BYTE_RESET;
      ext_ref_q   <= 1'b0;
    end else begin
      sel_flash_q <= sel_flash_d;
      sel_cfg_q   <= sel_cfg_d;
      erase_sel_q <= erase_sel_d;
      err_q       <= err_d;
      wr_en_q     <= wr_en_d;
      wr_q        <= wr_d;
      rd_q        <= rd_d;
      unlock_q    <= unlock_d;
      addr_lo_q   <= addr_lo_d;
      addr_hi_q   <= addr_hi_d;
      data_q      <= data_d;
      latch_q     <= latch_d;
      tptr_q      <= tptr_d;
      state_q     <= state_d;
      cnt_q       <= cnt_d;
      pwr_cnt_q   <= pwr_cnt_d;
      pwr_busy_q  <= pwr_busy_d;
      rdata_q     <= rdata_d;
      fdata_q     <= fdata_d;
      stall_q     <= stall_d;
      ext_rdata_q <= ext_rdata_d;
      ext_ref_q   <= ext_ref_d;
    end
  end

  // Array writes; a whole flash block moves at once, no single-byte flash path
  always_ff @(posedge clk_in) begin
    if (ee_commit) begin
      ee_mem[ee_addr] <= data_q;
    end else if (ext_commit) begin
      ee_mem[ext_addr_in] <= ext_wdata_in;
    end
    if (hold_wr) begin
      hold_mem[tptr_q[5:0]] <= latch_q;
    end
    for (int i = 0; i < BLOCK_BYTES; i++) begin
      if (fl_commit) begin
        flash_mem[{blk, 6'(i)}] <= hold_mem[i];
        hold_mem[i]             <= ERASED_BYTE;
      end else if (fl_erase) begin
        flash_mem[{blk, 6'(i)}] <= ERASED_BYTE;
      end
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata_out   = rdata_q;
  assign fetch_data_out  = fdata_q;
  assign fetch_stall_out = stall_q;
  assign ext_rdata_out   = ext_rdata_q;
  assign ext_refused_out = ext_ref_q;

endmodule

`default_nettype wire

// File: verif/nv_ctrl_checker_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module nv_ctrl_checker #(
  parameter int FLASH_PROG_CYCLES = 10
) (
  // Clock, reset, register port
  input wire logic        clk_in,
  input wire logic        sys_rst_in,
  input wire logic [3:0]  reg_addr_in,
  input wire logic [7:0]  reg_wdata_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [7:0]  reg_rdata_out,
  // Fetch and external ports
  input wire logic [15:0] fetch_data_out,
  input wire logic        fetch_stall_out,
  input wire logic        code_protect_in,
  input wire logic        ext_rd_in,
  input wire logic        ext_wr_in,
  input wire logic [7:0]  ext_rdata_out,
  input wire logic        ext_refused_out
);
  import nv_ctrl_pkg::*;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  int   stall_cnt_q; // Stalled cycles so far
  int   stall_cnt_d;
  logic start_wr;    // Control write asking for a start
  assign start_wr = reg_wr_in && reg_addr_in == REG_CONTROL &&
                    reg_wdata_in[CTL_WR_START];
  // Counter restarts whenever fetch runs
  always_comb begin
    stall_cnt_d = fetch_stall_out ? stall_cnt_q + 1 : 0;
  end
  always_ff @(posedge clk_in) begin
    stall_cnt_q <= sys_rst_in ? 0 : stall_cnt_d;
  end
  rdata_idle_a: assert property (
    !$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
    else $error("read data not zero when idle");
  ext_rdata_a: assert property (ext_rdata_out != 8'h00 |->
    $past(ext_rd_in) && !$past(code_protect_in))
    else $error("external data without accepted read");
  protect_refuse_a: assert property (
    (ext_rd_in || ext_wr_in) && code_protect_in
    |=> ext_refused_out && ext_rdata_out == 8'h00)
    else $error("protected external access not refused");
  refuse_cause_a: assert property (
    ext_refused_out |-> $past(ext_rd_in || ext_wr_in))
    else $error("refusal without external access");
  stall_start_a: assert property ($rose(fetch_stall_out) |->
    $past(start_wr) || $past(start_wr, 2))
    else $error("stall without start request");
  stall_len_a: assert property ($fell(fetch_stall_out) |->
    stall_cnt_q inside {[FLASH_PROG_CYCLES:FLASH_PROG_CYCLES + 1]})
    else $error("programming stall length wrong");
  stall_bound_a: assert property (
    fetch_stall_out |-> stall_cnt_q <= FLASH_PROG_CYCLES)
    else $error("programming stall overran");
  fetch_hold_a: assert property (
    fetch_stall_out && $past(fetch_stall_out) && $past(fetch_stall_out, 2)
    |-> $stable(fetch_data_out))
    else $error("fetch word moved while stalled");
  reset_quiet_a: assert property ($past(sys_rst_in) |->
    !fetch_stall_out && reg_rdata_out == 8'h00 && !ext_refused_out)
    else $error("outputs busy right after reset");
  // Main scenarios reached
  cover property ($rose(fetch_stall_out));
  cover property ($fell(fetch_stall_out));
  cover property (ext_refused_out);
endmodule
bind nonvolatile_write_protect_ctrl nv_ctrl_checker #(
  .FLASH_PROG_CYCLES(FLASH_PROG_CYCLES)
) u_chk (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .fetch_data_out(fetch_data_out),
  .fetch_stall_out(fetch_stall_out), .code_protect_in(code_protect_in),
  .ext_rd_in(ext_rd_in), .ext_wr_in(ext_wr_in),
  .ext_rdata_out(ext_rdata_out), .ext_refused_out(ext_refused_out)
);
`default_nettype wire

// File: verif/core_bus_model.sv
`timescale 1ns/10ps
`default_nettype none
module core_bus_model (
  // Clock and read data back
  input  wire logic       clk_in,
  input  wire logic [7:0] rdata_in,
  // Register strobes and payload
  output var logic  [3:0] addr_out,
  output var logic  [7:0] wdata_out,
  output var logic        wr_out,
  output var logic        rd_out
);
  initial begin
    addr_out = 4'h0;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  // One-cycle write; payload inverted after so stale data never helps
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= v;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~v;
  endtask
  // One-cycle read; data taken in the cycle after
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    addr_out <= ~a;
    #1 v = rdata_in;
  endtask
  // Two keys then the start write; keys may be wrong on purpose
  task automatic unlock_start(input logic [7:0] k1, k2, ctl);
    wr(nv_ctrl_pkg::REG_UNLOCK, k1);
    wr(nv_ctrl_pkg::REG_UNLOCK, k2);
    wr(nv_ctrl_pkg::REG_CONTROL, ctl);
  endtask
endmodule
`default_nettype wire

// File: verif/tb_nonvolatile_write_protect_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module tb_nonvolatile_write_protect_ctrl;
  import nv_ctrl_pkg::*;
  logic        clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, ext_wdata = 8'h00, ext_rdata, d;
  logic        reg_wr, reg_rd, stall, protect = 1'b0, ext_ref;
  logic        ext_rd = 1'b0, ext_wr = 1'b0;
  logic [14:0] fetch_addr = 15'h0000;
  logic [15:0] fetch_data;
  logic [9:0]  ext_addr = 10'h000;
  int          miscompares = 0, n_compared = 0, cycles = 0;
  // Refusal table: pre-write, keys, start value, expected control
  logic [7:0]  pre[4] = '{8'h04, 8'h04, 8'h04, 8'h00};
  logic [7:0]  k1[4] = '{8'h55, 8'h55, 8'haa, 8'h55};
  logic [7:0]  k2[4] = '{8'haa, 8'h55, 8'h55, 8'haa};
  logic [7:0]  st[4] = '{8'h06, 8'h06, 8'h06, 8'h02};
  logic [7:0]  ex[4] = '{8'h0c, 8'h0c, 8'h0c, 8'h08};
  always #4 clk_in = ~clk_in;
  core_bus_model u_core (.clk_in(clk_in), .rdata_in(reg_rdata),
    .addr_out(reg_addr), .wdata_out(reg_wdata), .wr_out(reg_wr),
    .rd_out(reg_rd));
  // Short counts keep the run brief
  nonvolatile_write_protect_ctrl #(.POWERUP_CYCLES(60),
    .EE_WRITE_CYCLES(10), .FLASH_PROG_CYCLES(10)) u_dut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_rdata_out(reg_rdata), .fetch_addr_in(fetch_addr),
    .fetch_data_out(fetch_data), .fetch_stall_out(stall),
    .code_protect_in(protect), .ext_rd_in(ext_rd), .ext_wr_in(ext_wr),
    .ext_addr_in(ext_addr), .ext_wdata_in(ext_wdata),
    .ext_rdata_out(ext_rdata), .ext_refused_out(ext_ref));
  task automatic check(input string what, input logic [15:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report();
    if (miscompares == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Hang guard, well above the expected run length
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 4000) begin
      miscompares++;
      final_report();
    end
  end
  function automatic logic [7:0] pat(input int i);
    return 8'(i * 37 + 11);
  endfunction
  task automatic ee_write(input logic [9:0] a, input logic [7:0] v);
    u_core.wr(REG_ADDR_LOW, a[7:0]);
    u_core.wr(REG_ADDR_HIGH, {6'h00, a[9:8]});
    u_core.wr(REG_DATA, v);
    u_core.wr(REG_CONTROL, 8'h04);
    u_core.unlock_start(8'h55, 8'haa, 8'h06);
    u_core.rd(REG_CONTROL, d);
    check("ctl_busy", 8'h06, d);
    for (int n = 0; n < 20 && d[CTL_WR_START] !== 1'b0; n++)
      u_core.rd(REG_CONTROL, d);
    check("ctl_done", 8'h04, d);
  endtask
  task automatic ee_read(input logic [9:0] a, output logic [7:0] v);
    u_core.wr(REG_ADDR_LOW, a[7:0]);
    u_core.wr(REG_ADDR_HIGH, {6'h00, a[9:8]});
    u_core.wr(REG_CONTROL, 8'h01);
    u_core.rd(REG_DATA, v);
  endtask
  // External access; protect level set at the same edge
  task automatic ext_op(input logic w, p, input logic [9:0] a);
    @(posedge clk_in);
    protect <= p;
    ext_rd <= !w;
    ext_wr <= w;
    ext_addr <= a;
    ext_wdata <= 8'h77;
    @(posedge clk_in);
    ext_rd <= 1'b0;
    ext_wr <= 1'b0;
    ext_addr <= ~a;
    ext_wdata <= 8'h88;
    #1;
  endtask
  task automatic wait_prog();
    int n = 0;
    while (stall !== 1'b1 && n < 4) begin
      @(posedge clk_in);
      #1 n++;
    end
    check("stall_on", 16'h1, stall);
    @(posedge clk_in);
    fetch_addr <= 15'h0011;
    n = 0;
    while (stall !== 1'b0 && n < 40) begin
      @(posedge clk_in);
      #1 n++;
    end
    check("stall_off", 16'h0, stall);
  endtask
  initial begin
    repeat (5) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    u_core.rd(REG_STATUS, d);
    check("status_reset", 8'h01, d);
    u_core.rd(REG_CONTROL, d);
    check("ctl_reset", 8'h00, d);
    u_core.rd(4'hf, d);
    check("unmapped", 8'h00, d);
    // Outside write during the power-up timer must bounce
    ext_op(1'b1, 1'b0, 10'h224);
    check("ext_ref_pwr", 16'h1, ext_ref);
    // Case 0 lands inside the power-up interval
    for (int i = 0; i < 4; i++) begin
      if (i == 1) begin
        do u_core.rd(REG_STATUS, d);
        while (d[STAT_POWERUP] !== 1'b0 && cycles < 3000);
      end
      u_core.wr(REG_CONTROL, pre[i]);
      u_core.unlock_start(k1[i], k2[i], st[i]);
      u_core.rd(REG_CONTROL, d);
      check("ctl_refused", ex[i], d);
    end
    ee_write(10'h223, 8'h5a);
    ee_write(10'h224, 8'hc3);
    ee_read(10'h223, d);
    check("ee_byte0", 8'h5a, d);
    ee_read(10'h224, d);
    check("ee_byte1", 8'hc3, d);
    u_core.rd(REG_CONTROL, d);
    check("rd_clear", 8'h00, d & 8'h01);
    ext_op(1'b0, 1'b0, 10'h223);
    check("ext_rd", 8'h5a, ext_rdata);
    ext_op(1'b0, 1'b1, 10'h223);
    check("ext_rd_prot", 8'h00, ext_rdata);
    check("ext_ref_rd", 16'h1, ext_ref);
    ext_op(1'b1, 1'b1, 10'h224);
    check("ext_ref_wr", 16'h1, ext_ref);
    ee_write(10'h225, 8'h99);
    ee_read(10'h225, d);
    check("ee_prot_wr", 8'h99, d);
    ee_read(10'h224, d);
    check("ee_kept", 8'hc3, d);
    ext_op(1'b1, 1'b0, 10'h226);
    check("ext_ok", 16'h0, ext_ref);
    ee_read(10'h226, d);
    check("ee_ext_wr", 8'h77, d);
    // Fill holding registers, program block 1, then erase it
    u_core.wr(REG_TPTR_HIGH, 8'h00);
    u_core.wr(REG_TPTR_LOW, 8'h40);
    for (int i = 0; i < 64; i++) begin
      u_core.wr(REG_TABLE_LATCH, pat(i));
      u_core.wr(REG_TABLE_CMD, 8'h06);
    end
    for (int e = 0; e < 2; e++) begin
      u_core.wr(REG_TPTR_LOW, 8'h40);
      u_core.wr(REG_CONTROL, e ? 8'h94 : 8'h84);
      u_core.unlock_start(8'h55, 8'haa, e ? 8'h96 : 8'h86);
      wait_prog();
      for (int w = 0; w < 32; w += 31) begin
        @(posedge clk_in);
        fetch_addr <= 15'(32 + w);
        @(posedge clk_in);
        #1 check("fetch", e ? 16'hffff : {pat(2*w+1), pat(2*w)},
          fetch_data);
      end
      u_core.wr(REG_TPTR_LOW, 8'h45);
      u_core.wr(REG_TABLE_CMD, 8'h01);
      u_core.rd(REG_TABLE_LATCH, d);
      check("table_rd", e ? 8'hff : pat(5), d);
    end
    u_core.wr(REG_CONTROL, 8'h24);
    u_core.rd(REG_CONTROL, d);
    check("bulk_err", 8'h08, d & 8'h08);
    check("bulk_stall", 16'h0, stall);
    final_report();
  end
endmodule
`default_nettype wire
